// *** core/standby_mode_controller.sv ***
`timescale 1ns/1ps
module standby_mode_controller
	import standby_pkg::*;
#(
	parameter int unsigned NIRQ  = 16,
	parameter logic [17:0] WU_N0 = WU_N0_DEF,
	parameter logic [17:0] WU_N1 = WU_N1_DEF,
	parameter logic [17:0] WU_N2 = WU_N2_DEF,
	parameter logic [17:0] WU_N3 = WU_N3_DEF,
	parameter logic [17:0] WU_S0 = WU_S0_DEF,
	parameter logic [17:0] WU_S1 = WU_S1_DEF,
	parameter logic [17:0] WU_S2 = WU_S2_DEF,
	parameter logic [17:0] WU_S3 = WU_S3_DEF
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            clk_en,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire logic            wake_pin,
	input  wire logic [4:0]      keyon_wake_input,
	input  wire logic            reset_pin_n,
	input  wire logic            fc_tick,
	input  wire logic            fs_tick,
	input  wire logic [3:0]      tb_src,
	input  wire logic [NIRQ-1:0] irq_req,
	input  wire logic            wdt_irq,
	output pwr_t                 pwr,
	output logic                 sys_reset,
	output logic                 irq_service,
	output logic                 resume
);

	// ****************************************
	// declarations
	// ****************************************
	state_t            state_r;
	state_t            state_nxt;
	ctrl_t             ctrl_r;
	pwr_t              pwr_r;
	pwr_t              pwr_nxt;
	logic [NIRQ-1:0]   en_r;
	logic [NIRQ-1:0]   latch_r;
	logic [NIRQ-1:0]   latch_clr;
	logic [NIRQ-1:0]   tb_set;
	logic              imf_r;
	logic              tben_r;
	logic [1:0]        tck_r;
	logic [17:0]       cnt_r;
	logic [17:0]       lim;
	logic              tick;
	logic              cnt_done;
	logic              wake_d_r;
	logic              wake_rise;
	logic              wake_rel;
	logic              tb_d_r;
	logic              tb_sel;
	logic              tb_fall;
	logic              irq_wake;
	logic              addr_ok;
	logic              wr_pend_r;
	logic [7:0]        wr_ofs_r;
	logic              ctrl_wr;
	logic              stop_go;
	logic [31:0]       rd_val;
	logic [31:0]       hrdata_r;
	logic              hreadyout_r;
	logic              hresp_r;
	logic              sys_reset_r;
	logic              irq_service_r;
	logic              resume_r;

	assign hrdata      = hrdata_r;
	assign hreadyout   = hreadyout_r;
	assign hresp       = hresp_r;
	assign pwr         = pwr_r;
	assign sys_reset   = sys_reset_r;
	assign irq_service = irq_service_r;
	assign resume      = resume_r;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn || !clk_en);

	// ****************************************
	// bus slave
	// ****************************************
	// zero wait states; hsize is ignored, whole words only
	assign addr_ok = hsel && hready && htrans[1];
	assign ctrl_wr = wr_pend_r && (wr_ofs_r == OFS_CTRL);
	assign stop_go = ctrl_wr && hwdata[0];

	always_comb begin
		rd_val = RST_VAL;
		case (haddr[7:0])
			OFS_CTRL: rd_val[9:1] = ctrl_r;
			OFS_IRQEN: begin
				rd_val[NIRQ-1:0]        = en_r;
				rd_val[EB_IMF]          = imf_r;
				rd_val[EB_TBEN]         = tben_r;
				rd_val[EB_TCK+1:EB_TCK] = tck_r;
			end
			OFS_LATCH: rd_val[NIRQ-1:0] = latch_r;
			OFS_STAT: begin
				rd_val[6:0]  = state_r;
				rd_val[13:8] = pwr_r;
			end
			default: rd_val = RST_VAL;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r   <= 1'b0;
			wr_ofs_r    <= 8'h00;
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b0;
			hresp_r     <= 1'b0;
		end else if (clk_en) begin
			hreadyout_r <= 1'b1;
			wr_pend_r   <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_ofs_r <= haddr[7:0];
			end
			if (addr_ok && !hwrite) begin
				hrdata_r <= rd_val;
			end
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= ctrl_t'(RST_VAL[8:0]);
		end else if (clk_en) begin
			if (!reset_pin_n) begin
				ctrl_r.slow     <= 1'b0;
				ctrl_r.dual     <= 1'b0;
				ctrl_r.idle     <= 1'b0;
				ctrl_r.clk_halt <= 1'b0;
			end else begin
				if (ctrl_wr) begin
					ctrl_r <= ctrl_t'(hwdata[9:1]);
				end
				if (state_r == ST_HALT && state_nxt != ST_HALT) begin
					ctrl_r.idle <= 1'b0;
				end
				if (state_r == ST_GATE && state_nxt != ST_GATE) begin
					ctrl_r.clk_halt <= 1'b0;
				end
				// a pending watchdog event cancels the idle and clock-halt requests outright; a standby start strobe still goes through
				if (state_r == ST_RUN && wdt_irq) begin
					ctrl_r.idle     <= 1'b0;
					ctrl_r.clk_halt <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// interrupt enables and latches
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_r   <= '0;
			imf_r  <= 1'b0;
			tben_r <= 1'b0;
			tck_r  <= 2'h0;
		end else if (clk_en && wr_pend_r && wr_ofs_r == OFS_IRQEN) begin
			en_r   <= hwdata[NIRQ-1:0];
			imf_r  <= hwdata[EB_IMF];
			tben_r <= hwdata[EB_TBEN];
			tck_r  <= hwdata[EB_TCK+1:EB_TCK];
		end
	end

	always_comb begin
		latch_clr = '0;
		tb_set    = '0;
		if (wr_pend_r && wr_ofs_r == OFS_LATCH) begin
			latch_clr = hwdata[NIRQ-1:0];
		end
		tb_set[TB_IDX] = (state_r == ST_GATE) && tb_fall && tben_r;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_r <= '0;
		end else if (clk_en) begin
			latch_r <= (latch_r & ~latch_clr) | irq_req | tb_set;
		end
	end

	// master enable plays no part in waking
	assign irq_wake = |(latch_r & en_r);

	// ****************************************
	// wake sources
	// ****************************************
	assign wake_rise = wake_pin && !wake_d_r;
	// key-on inputs only count in level mode
	assign wake_rel  = ctrl_r.rel_lvl ? (wake_pin || |keyon_wake_input) : wake_rise;
	assign tb_sel    = tb_src[tck_r];
	assign tb_fall   = tb_d_r && !tb_sel;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_d_r <= 1'b0;
			tb_d_r   <= 1'b0;
		end else if (clk_en) begin
			wake_d_r <= wake_pin;
			tb_d_r   <= tb_sel;
		end
	end

	// ****************************************
	// warm-up and wait counter
	// ****************************************
	assign tick = ctrl_r.slow ? fs_tick : fc_tick;

	always_comb begin
		if (state_r == ST_WARM) begin
			case (ctrl_r.warmup_select)
				2'h0:    lim = ctrl_r.slow ? WU_S0 : WU_N0;
				2'h1:    lim = ctrl_r.slow ? WU_S1 : WU_N1;
				2'h2:    lim = ctrl_r.slow ? WU_S2 : WU_N2;
				default: lim = ctrl_r.slow ? WU_S3 : WU_N3;
			endcase
		end else begin
			lim = ctrl_r.slow ? FW_FS : FW_FC;
		end
	end

	assign cnt_done = tick && (cnt_r == 18'(lim - 18'h00001));

	// counter only runs on oscillator ticks, so a stopped source stalls it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 18'h00000;
		end else if (clk_en) begin
			if (state_nxt != state_r) begin
				cnt_r <= 18'h00000;
			end else if (tick) begin
				cnt_r <= 18'(cnt_r + 18'h00001);
			end
		end
	end

	// ****************************************
	// mode sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (stop_go) begin
					state_nxt = ST_STOP;
				end else if (ctrl_r.idle && !wdt_irq) begin
					state_nxt = ST_HALT;
				end else if (ctrl_r.clk_halt && !wdt_irq) begin
					state_nxt = ST_GATE;
				end
			end
			ST_STOP: begin
				if (wake_rel) begin
					state_nxt = ST_WARM;
				end
			end
			ST_WARM: begin
				if (cnt_done) begin
					state_nxt = ctrl_r.stby_fw ? ST_FWAIT : ST_RUN;
				end
			end
			ST_HALT: begin
				if (irq_wake) begin
					state_nxt = ctrl_r.idle_fw ? ST_RUN : ST_CWAIT;
				end
			end
			ST_GATE: begin
				if (tb_fall) begin
					state_nxt = ctrl_r.idle_fw ? ST_RUN : ST_CWAIT;
				end
			end
			ST_FWAIT, ST_CWAIT: begin
				if (cnt_done) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
		if (!reset_pin_n) begin
			state_nxt = ST_RUN;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_RUN;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// power outputs
	// ****************************************
	always_comb begin
		pwr_nxt.hf_osc      = !(ctrl_r.dual && ctrl_r.slow);
		pwr_nxt.lf_osc      = ctrl_r.dual;
		pwr_nxt.cpu_halt    = state_nxt != ST_RUN;
		pwr_nxt.wdt_halt    = state_nxt != ST_RUN;
		pwr_nxt.periph_halt = state_nxt inside {ST_STOP, ST_WARM, ST_GATE};
		pwr_nxt.div_clear   = state_nxt inside {ST_STOP, ST_WARM};
		if (state_nxt == ST_STOP) begin
			pwr_nxt.hf_osc = 1'b0;
			pwr_nxt.lf_osc = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_r         <= pwr_t'(6'h20);
			sys_reset_r   <= 1'b0;
			irq_service_r <= 1'b0;
			resume_r      <= 1'b0;
		end else if (clk_en) begin
			pwr_r       <= pwr_nxt;
			sys_reset_r <= !reset_pin_n;
			resume_r    <= state_r != ST_RUN && state_nxt == ST_RUN;
			// service only in run; waits hold latched events back
			irq_service_r <= state_nxt == ST_RUN && reset_pin_n &&
				(wdt_irq || (imf_r && irq_wake));
		end
	end

	// ****************************************
	// checks
	// ****************************************
	edge_release_a: assert property (
		state_r == ST_STOP && !ctrl_r.rel_lvl && !wake_rise && reset_pin_n
		|=> state_r == ST_STOP)
		else $error("standby left without a wake edge");
	stop_entry_a: assert property (
		state_r == ST_RUN && stop_go && reset_pin_n |=> state_r == ST_STOP)
		else $error("standby start command not taken");
	osc_select_a: assert property (
		state_r == ST_WARM && $stable(ctrl_r)
		|-> pwr_r.hf_osc == !(ctrl_r.dual && ctrl_r.slow) && pwr_r.lf_osc == ctrl_r.dual)
		else $error("wrong oscillator set on release");
	warm_halt_a: assert property (
		state_r == ST_WARM |-> pwr_r.cpu_halt && pwr_r.periph_halt)
		else $error("activity during warm-up");
	warm_exit_a: assert property (
		state_r == ST_WARM && cnt_done && reset_pin_n
		|=> state_r == ($past(ctrl_r.stby_fw) ? ST_FWAIT : ST_RUN))
		else $error("wrong step after warm-up");
	flash_wait_a: assert property (
		state_r == ST_FWAIT |-> pwr_r.cpu_halt && !pwr_r.periph_halt && !pwr_r.div_clear)
		else $error("flash wait outputs wrong");
	div_clear_a: assert property (
		state_r == ST_STOP ##1 state_r == ST_WARM |-> pwr_r.div_clear)
		else $error("divider not cleared at release");
	pin_reset_a: assert property (
		!reset_pin_n |=> state_r == ST_RUN && !ctrl_r.slow && !ctrl_r.dual && sys_reset)
		else $error("reset pin did not release");
	halt_clear_a: assert property (
		state_r == ST_HALT ##1 state_r != ST_HALT |-> !ctrl_r.idle)
		else $error("idle bit not cleared on release");
	wait_len_a: assert property (
		state_r == ST_CWAIT |-> cnt_r < (ctrl_r.slow ? FW_FS : FW_FC))
		else $error("post-idle wait overran");
	no_service_a: assert property (
		state_r != ST_RUN |-> !irq_service)
		else $error("interrupt serviced while halted");
	gate_release_a: assert property (
		state_r == ST_GATE && tb_fall && reset_pin_n
		|=> state_r != ST_GATE && !ctrl_r.clk_halt)
		else $error("clock-gated mode not released");

	stop_cycle_c: cover property (state_r == ST_WARM ##1 state_r == ST_FWAIT);
	halt_cycle_c: cover property (state_r == ST_HALT ##1 state_r == ST_CWAIT);
	gate_cycle_c: cover property (state_r == ST_GATE ##1 state_r == ST_RUN);

endmodule

// *** core/standby_pkg.sv ***
// Overview of operation
// - edge mode leaves standby only on a rising wake pin edge or with the reset pin low.
// - edge mode enters standby on command even with wake pin high.
// - release enables oscillators per single/dual clock and normal/slow return.
// - warm-up follows restart, all halted, length from 2-bit select.
// - flash wait bit 1 adds CPU wait; peripherals and divider resume.
// - flash wait bit 0 resumes the CPU right after warm-up.
// - prescaler and divider are cleared before restart.
// - reset pin low releases standby and starts reset at once.
// - CPU-halt modes stop CPU and watchdog; peripherals keep running.
// - idle bit enters CPU-halt; hardware clears it on release.
// - master enable 0: enabled interrupt wakes, latch stays, no service.
// - master enable 1: enabled interrupt wakes and is serviced first.
// - idle flash-wait bit 0 adds 2^10 fc or 2^3 fs wait.
// - no interrupt service during any post-idle CPU wait.
// - watchdog interrupt just before idle start cancels the entry.
// - reset pin releases idle/sleep; restart in single-clock normal.
// - clock-halt bit gates peripheral clocks except the time base.
// - clock-gated release ignores the enables; hardware clears clock-halt bit.
// - time-base enable set sets the time-base interrupt latch.
// - clock-gated return with idle flash-wait bit 0 adds 2^10 fc or 2^3 fs wait.
// - warm-up codes give the listed fc and fs cycle counts.
// - clock-gated release on falling edge of selected time-base source.
package standby_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0]  OFS_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_IRQEN = 8'h04;
	localparam logic [7:0]  OFS_LATCH = 8'h08;
	localparam logic [7:0]  OFS_STAT  = 8'h0C;
	localparam int          EB_IMF    = 16;
	localparam int          EB_TBEN   = 17;
	localparam int          EB_TCK    = 18;
	localparam int          TB_IDX    = 7;
	localparam logic [31:0] RST_VAL   = 32'h0000_0000;

	// ****************************************
	// timing counts in oscillator ticks
	// ****************************************
	localparam logic [17:0] WU_N0_DEF = 18'h30000;
	localparam logic [17:0] WU_N1_DEF = 18'h10000;
	localparam logic [17:0] WU_N2_DEF = 18'h0C000;
	localparam logic [17:0] WU_N3_DEF = 18'h04000;
	localparam logic [17:0] WU_S0_DEF = 18'h06000;
	localparam logic [17:0] WU_S1_DEF = 18'h02000;
	localparam logic [17:0] WU_S2_DEF = 18'h000C0;
	localparam logic [17:0] WU_S3_DEF = 18'h00040;
	localparam logic [17:0] FW_FC     = 18'h00400;
	localparam logic [17:0] FW_FS     = 18'h00008;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [6:0] {
		ST_RUN   = 7'h01,
		ST_STOP  = 7'h02,
		ST_WARM  = 7'h04,
		ST_FWAIT = 7'h08,
		ST_HALT  = 7'h10,
		ST_GATE  = 7'h20,
		ST_CWAIT = 7'h40
	} state_t;

	// control register bits 9:1, bit 0 is the write-only start strobe
	typedef struct packed {
		logic       dual;
		logic       slow;
		logic       clk_halt;
		logic       idle;
		logic       idle_fw;
		logic       stby_fw;
		logic [1:0] warmup_select;
		logic       rel_lvl;
	} ctrl_t;

	typedef struct packed {
		logic hf_osc;
		logic lf_osc;
		logic cpu_halt;
		logic wdt_halt;
		logic periph_halt;
		logic div_clear;
	} pwr_t;

endpackage

// *** sim/standby_far_side.sv ***
`timescale 1ns/1ps
// ****************************************
// wake pin, reset pin, interrupt sources, ticks
// ****************************************
module standby_far_side (
	input  wire logic        hclk,
	output logic             wake_pin,
	output logic [4:0]       keyon_wake_input,
	output logic             reset_pin_n,
	output logic             fc_tick,
	output logic             fs_tick,
	output logic [3:0]       tb_src,
	output logic [15:0]      irq_req,
	output logic             wdt_irq
);
	initial begin
		wake_pin = 1'b0;
		keyon_wake_input = 5'h00;
		reset_pin_n = 1'b1;
		fc_tick = 1'b0;
		fs_tick = 1'b0;
		tb_src = 4'hF;
		irq_req = 16'h0000;
		wdt_irq = 1'b0;
	end
	// fs at half rate so slow timing differs from fast
	always @(posedge hclk) begin
		fc_tick <= 1'b1;
		fs_tick <= ~fs_tick;
	end
	task automatic drive(input logic [2:0] sel, input logic [15:0] v);
		@(posedge hclk);
		case (sel)
			3'h0: wake_pin <= v[0];
			3'h1: keyon_wake_input <= v[4:0];
			3'h2: reset_pin_n <= v[0];
			3'h3: tb_src <= v[3:0];
			3'h4: irq_req <= v;
			default: wdt_irq <= v[0];
		endcase
	endtask
endmodule

// *** sim/standby_mode_controller_tb_top.sv ***
`timescale 1ns/1ps
module standby_mode_controller_tb_top;
	import standby_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        clk_en = 1'b1;
	logic        hsel = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic        hresp;
	logic [31:0] hrdata, q;
	logic        hreadyout, sys_reset, irq_service, resume;
	logic        wake_pin, reset_pin_n, fc_tick, fs_tick, wdt_irq;
	logic [4:0]  keys;
	logic [3:0]  tb_src;
	logic [15:0] irq_req;
	pwr_t        pwr;
	int          mismatches = 0;
	int          n_compared = 0;

	always #2 hclk = ~hclk;

	// only slow code 00 is run, so the other slow counts keep their defaults
	standby_mode_controller #(.WU_N0(18'h10), .WU_N1(18'h8), .WU_N2(18'h4), .WU_N3(18'h2),
		.WU_S0(18'h10))
	standby_mode_controller_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wake_pin(wake_pin), .keyon_wake_input(keys), .reset_pin_n(reset_pin_n),
		.fc_tick(fc_tick), .fs_tick(fs_tick), .tb_src(tb_src), .irq_req(irq_req),
		.wdt_irq(wdt_irq), .pwr(pwr), .sys_reset(sys_reset), .irq_service(irq_service),
		.resume(resume));
	standby_far_side standby_far_side_inst (.hclk(hclk), .wake_pin(wake_pin),
		.keyon_wake_input(keys), .reset_pin_n(reset_pin_n), .fc_tick(fc_tick),
		.fs_tick(fs_tick), .tb_src(tb_src), .irq_req(irq_req), .wdt_irq(wdt_irq));

	// ****************************************
	// report and compare
	// ****************************************
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int n, input int lo, input int hi);
		n_compared++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
		end
	endtask
	task automatic drv(input logic [2:0] s, input logic [15:0] v);
		standby_far_side_inst.drive(s, v);
	endtask

	// ****************************************
	// bus and waits
	// ****************************************
	// ready and read data are taken at the rising edge that ends the phase
	task automatic hrdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			q = hrdata;
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			end_sim();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hrdy();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
		chk({31'h0, hresp}, 32'h0);
	endtask
	// irq service sampled only up to k: the run entry edge may raise it
	task automatic wres(input int k, output int n, output pwr_t pk, output logic svc);
		n = 0;
		svc = 1'b0;
		pk = '0;
		do begin
			@(negedge hclk);
			n++;
			if (n == k) pk = pwr;
			if (n <= k && irq_service === 1'b1) svc = 1'b1;
		end while (resume !== 1'b1 && n < 3000);
		if (resume !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		@(posedge hclk);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_stby(input logic [1:0] warmup_select, input logic fw, input logic dual,
		input logic slow, input logic [1:0] osc);
		int n, lim, fl;
		pwr_t pk;
		logic s;
		lim = slow ? (32 >> warmup_select) : (16 >> warmup_select);
		fl = fw ? (slow ? 16 : 1024) : 0;
		drv(3'h0, 16'h1);
		wr(8'h00, {22'h0, dual, slow, 3'h0, fw, warmup_select, 1'b0, 1'b1});
		rdc(8'h0C, 32'h317F, 32'h0102);
		drv(3'h1, 16'h1F);
		repeat (20) @(negedge hclk);
		chk({30'h0, pwr[5:4]}, 32'h0);
		drv(3'h1, 16'h0);
		drv(3'h0, 16'h0);
		drv(3'h0, 16'h1);
		wres(fw ? lim + fl - 10 : 4, n, pk, s);
		rng(n, lim + fl, lim + fl + 8);
		if (fw) chk({29'h0, pk[3], pk[1:0]}, 32'h4);
		if (!fw && warmup_select == 2'h0) chk({30'h0, pk[5:4]}, {30'h0, osc});
	endtask
	task automatic t_halt(input logic master_irq_enable, input logic fw);
		int n;
		pwr_t pk;
		logic s;
		wr(8'h04, {15'h0, master_irq_enable, 16'h0008});
		wr(8'h00, {25'h0, 1'b1, fw, 5'h0});
		// mode entry comes one edge after the write lands
		@(posedge hclk);
		rdc(8'h0C, 32'h0E7F, 32'h0C10);
		drv(3'h4, 16'h0008);
		wres(1000, n, pk, s);
		rng(n, fw ? 0 : 1024, fw ? 8 : 1032);
		chk({31'h0, s}, 32'h0);
		@(negedge hclk);
		chk({31'h0, irq_service}, {31'h0, master_irq_enable});
		@(posedge hclk);
		rdc(8'h00, 32'h40, 32'h0);
		rdc(8'h08, 32'h8, 32'h8);
		drv(3'h4, 16'h0);
		wr(8'h08, 32'h8);
		rdc(8'h08, 32'h8, 32'h0);
	endtask
	task automatic t_wdt;
		drv(3'h5, 16'h1);
		wr(8'h00, 32'h40);
		rdc(8'h0C, 32'h7F, 32'h01);
		rdc(8'h00, 32'h40, 32'h0);
		chk({31'h0, irq_service}, 32'h1);
		drv(3'h5, 16'h0);
	endtask
	task automatic t_gated(input logic fw);
		int n;
		pwr_t pk;
		logic s;
		wr(8'h04, 32'h000A0000);
		wr(8'h00, {24'h0, 1'b1, 1'b0, fw, 5'h0});
		@(posedge hclk);
		rdc(8'h0C, 32'h027F, 32'h0220);
		drv(3'h3, 16'hD);
		rdc(8'h0C, 32'h7F, 32'h20);
		drv(3'h3, 16'h9);
		wres(100, n, pk, s);
		rng(n, fw ? 0 : 1024, fw ? 8 : 1032);
		rdc(8'h00, 32'h80, 32'h0);
		rdc(8'h08, 32'h80, 32'h80);
		wr(8'h08, 32'h80);
		drv(3'h3, 16'hF);
	endtask
	task automatic t_level;
		int n;
		pwr_t pk;
		logic s;
		drv(3'h0, 16'h0);
		wr(8'h00, 32'h3);
		rdc(8'h0C, 32'h7F, 32'h02);
		drv(3'h1, 16'h4);
		wres(4, n, pk, s);
		rng(n, 16, 24);
		drv(3'h1, 16'h0);
	endtask
	// a wake edge while frozen must wait for the enable
	task automatic t_freeze;
		int n;
		pwr_t pk;
		logic s;
		wr(8'h00, 32'h1);
		clk_en <= 1'b0;
		drv(3'h0, 16'h1);
		repeat (8) @(negedge hclk);
		chk({26'h0, pwr}, 32'h0F);
		@(posedge hclk);
		clk_en <= 1'b1;
		wres(4, n, pk, s);
		rng(n, 16, 24);
	endtask
	task automatic t_rpin(input logic [31:0] c, input logic [31:0] st);
		wr(8'h00, c);
		@(posedge hclk);
		rdc(8'h0C, 32'h7F, st);
		drv(3'h2, 16'h0);
		repeat (3) @(negedge hclk);
		chk({31'h0, sys_reset}, 32'h1);
		drv(3'h2, 16'h1);
		rdc(8'h0C, 32'h7F, 32'h01);
		rdc(8'h00, 32'h3C0, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rdc(8'h0C, 32'h3F7F, 32'h2001);
		rdc(8'h10, 32'hFFFFFFFF, 32'h0);
		for (int w = 0; w < 4; w++) t_stby(w[1:0], 1'b0, 1'b0, 1'b0, 2'h2);
		t_stby(2'h0, 1'b0, 1'b1, 1'b0, 2'h3);
		t_stby(2'h0, 1'b0, 1'b1, 1'b1, 2'h1);
		t_stby(2'h1, 1'b1, 1'b0, 1'b0, 2'h2);
		t_level();
		t_freeze();
		t_halt(1'b0, 1'b1);
		t_halt(1'b1, 1'b0);
		t_wdt();
		t_gated(1'b1);
		t_gated(1'b0);
		t_rpin(32'h1, 32'h02);
		t_rpin(32'h240, 32'h10);
		end_sim();
	end
endmodule
